// ### include/tmcr_defines.svh
`ifndef TMCR_DEFINES_SVH
`define TMCR_DEFINES_SVH

// Register offsets
`define TMCR_ADDR_TEST 8'h6F
`define TMCR_ADDR_OFS_R1 8'h70
`define TMCR_ADDR_OFS_LOC 8'h71
`define TMCR_ADDR_OFS_R2 8'h72
`define TMCR_ADDR_CFG2 8'h73
`define TMCR_ADDR_CHSEL 8'h55

// Reset values
`define TMCR_RST_TEST 8'h00
`define TMCR_RST_OFS 8'h00
`define TMCR_RST_CFG2 8'h00

// Field positions in the second configuration, test and channel select registers
`define TMCR_BIT_DETECT_EN 0
`define TMCR_BIT_FAN1 1
`define TMCR_BIT_FAN3 3
`define TMCR_BIT_AVG_OFF 4
`define TMCR_BIT_BYPASS 5
`define TMCR_BIT_SINGLE 6
`define TMCR_BIT_HALT 7
`define TMCR_BIT_TEST_EN 0
`define TMCR_CHSEL_HI 7
`define TMCR_CHSEL_LO 5

`endif

// ### include/tmcr_pkg.sv
`default_nettype none
package tmcr_pkg;
	// Input selected in single-channel mode
	typedef enum logic [2:0] {
		TMCR_CH_RSV0 = 3'b000,
		TMCR_CH_CORE = 3'b001,
		TMCR_CH_SUPPLY = 3'b010,
		TMCR_CH_RSV3 = 3'b011,
		TMCR_CH_RSV4 = 3'b100,
		TMCR_CH_REMOTE1 = 3'b101,
		TMCR_CH_LOCAL = 3'b110,
		TMCR_CH_REMOTE2 = 3'b111
	} tmcr_chan_e;

	// Conversion sequencer state
	typedef enum logic [1:0] {
		TMCR_SEQ_IDLE = 2'b00,
		TMCR_SEQ_CONVERT = 2'b01,
		TMCR_SEQ_HALT = 2'b10
	} tmcr_seq_e;
endpackage : tmcr_pkg
`default_nettype wire

// ### src/tmcr_temp_adjust.sv
`timescale 1ns/1ps
`default_nettype none
// Adds a signed half-degree offset to a raw temperature result, saturating
module tmcr_temp_adjust #(
	parameter int RESULT_W = 10
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic valid_in,
	input wire logic [RESULT_W-1:0] raw_in,
	input wire logic [7:0] offset_in,
	output logic [RESULT_W-1:0] adjusted_out,
	output logic valid_out
);
	// ********************
	// Parameter check
	// ********************
	initial begin
		if (RESULT_W < 9) begin
			$error("RESULT_W must be at least 9");
		end
	end

	typedef struct packed {
		logic [RESULT_W-1:0] result;
		logic valid;
	} tmcr_adj_s;

	tmcr_adj_s state_q;
	tmcr_adj_s state_d;
	logic signed [RESULT_W+1:0] sum;

	// ********************
	// Offset addition
	// ********************
	// Result LSB is a quarter degree, offset LSB a half degree
	always_comb begin
		sum = $signed({2'b00, raw_in}) + ($signed({{(RESULT_W-8){offset_in[7]}}, offset_in, 1'b0}));
		state_d = state_q;
		state_d.valid = valid_in;
		if (valid_in) begin
			if (sum < 0) begin
				state_d.result = '0;
			end else if (sum[RESULT_W]) begin
				state_d.result = '1;
			end else begin
				state_d.result = sum[RESULT_W-1:0];
			end
		end
	end

	// State register
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign adjusted_out = state_q.result;
	assign valid_out = state_q.valid;
endmodule : tmcr_temp_adjust
`default_nettype wire

// ### src/tmcr_config_regs.sv
// Contract
// (RQ1) Test enable bit 0 set enters board test mode; cleared returns normal.
// (RQ2) Host never writes test enable bits 7 to 1.
// (RQ3) Lock set makes test, offsets and config two read-only.
// (RQ4) Remote one offset, signed half degrees, added to every remote one result.
// (RQ5) Local offset, signed half degrees, added to every local result.
// (RQ6) Remote two offset, signed half degrees, added to every remote two result.
// (RQ7) Detect enable bit 0 makes bits 3 to 1 report four-wire fans.
// (RQ8) Bits 1 to 3 are read-only four-wire flags for fans one to three.
// (RQ9) Config bit 4 turns averaging off.
// (RQ10) Config bit 5 bypasses the core voltage input divider.
// (RQ11) Config bit 6 converts one selected input repeatedly.
// (RQ12) Selector bits 7 to 5 pick core, supply, remote one, local, remote two.
// (RQ13) Config bit 7 halts: all fan drives go to fan-off level per polarity.
// (RQ14) Reserved selector code performs no conversion, results stay unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "tmcr_defines.svh"
module tmcr_config_regs #(
	parameter int RESULT_W = 10,
	parameter int FAN_COUNT = 3
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	output logic [7:0] reg_rdata_out,
	input wire logic config_lock_in,
	input wire logic [2:0] channel_select_in,
	input wire logic [FAN_COUNT-1:0] four_wire_sense_in,
	input wire logic drive_polarity_invert_in,
	input wire logic [FAN_COUNT-1:0] fan_drive_in,
	output logic [FAN_COUNT-1:0] fan_drive_out,
	input wire logic single_channel_convert_done_in,
	input wire tmcr_pkg::tmcr_chan_e single_channel_convert_chan_in,
	input wire logic [RESULT_W-1:0] single_channel_convert_raw_in,
	output logic [RESULT_W-1:0] remote_one_temp_out,
	output logic [RESULT_W-1:0] local_temp_out,
	output logic [RESULT_W-1:0] remote_two_temp_out,
	output logic [RESULT_W-1:0] core_voltage_out,
	output logic [RESULT_W-1:0] supply_voltage_out,
	output logic single_channel_convert_start_out,
	output tmcr_pkg::tmcr_chan_e single_channel_convert_chan_out,
	output logic board_test_mode_enable_out,
	output logic averaging_disable_out,
	output logic core_input_divider_bypass_out,
	output logic single_channel_convert_out,
	output logic fan_halt_request_out
);
	import tmcr_pkg::*;

	// ********************
	// Parameter check
	// ********************
	initial begin
		if (FAN_COUNT != 3) begin
			$error("FAN_COUNT must be 3");
		end
		if (RESULT_W < 9 || RESULT_W > 16) begin
			$error("RESULT_W must lie in 9..16");
		end
	end

	// ********************
	// State
	// ********************
	typedef struct packed {
		logic test_en;
		logic [7:0] ofs_r1;
		logic [7:0] ofs_loc;
		logic [7:0] ofs_r2;
		logic [7:0] cfg2;
		logic [FAN_COUNT-1:0] sense_meta;
		logic [FAN_COUNT-1:0] sense_sync;
		logic [FAN_COUNT-1:0] fan_drive;
		logic [7:0] rdata;
		tmcr_seq_e seq;
		tmcr_chan_e chan;
		logic start;
		logic [RESULT_W-1:0] res_core;
		logic [RESULT_W-1:0] res_supply;
	} tmcr_regs_s;

	tmcr_regs_s state_q;
	tmcr_regs_s state_d;

	logic [RESULT_W-1:0] adj_r1;
	logic [RESULT_W-1:0] adj_loc;
	logic [RESULT_W-1:0] adj_r2;
	logic adj_r1_valid;
	logic adj_loc_valid;
	logic adj_r2_valid;
	logic [RESULT_W-1:0] res_r1_q;
	logic [RESULT_W-1:0] res_loc_q;
	logic [RESULT_W-1:0] res_r2_q;

	// Reserved selector codes name no input
	function automatic logic chan_is_real(input tmcr_chan_e ch);
		chan_is_real = (ch == TMCR_CH_CORE) || (ch == TMCR_CH_SUPPLY) ||
			(ch == TMCR_CH_REMOTE1) || (ch == TMCR_CH_LOCAL) || (ch == TMCR_CH_REMOTE2);
	endfunction : chan_is_real

	// Next channel in the scan order
	function automatic tmcr_chan_e chan_next(input tmcr_chan_e ch);
		case (ch)
			TMCR_CH_CORE: chan_next = TMCR_CH_SUPPLY;
			TMCR_CH_SUPPLY: chan_next = TMCR_CH_REMOTE1;
			TMCR_CH_REMOTE1: chan_next = TMCR_CH_LOCAL;
			TMCR_CH_LOCAL: chan_next = TMCR_CH_REMOTE2;
			default: chan_next = TMCR_CH_CORE;
		endcase
	endfunction : chan_next

	// ********************
	// Next state
	// ********************
	always_comb begin
		state_d = state_q;
		state_d.start = 1'b0;
		// Two-stage synchroniser for the fan sense pins
		state_d.sense_meta = four_wire_sense_in;
		state_d.sense_sync = state_q.sense_meta;

		// Register writes
		// (RQ3) lock blocks writes
		if (reg_write_in && !config_lock_in) begin
			if (reg_addr_in == `TMCR_ADDR_TEST) begin
				// (RQ1) test mode bit
				state_d.test_en = reg_wdata_in[`TMCR_BIT_TEST_EN];
			end else if (reg_addr_in == `TMCR_ADDR_OFS_R1) begin
				state_d.ofs_r1 = reg_wdata_in;
			end else if (reg_addr_in == `TMCR_ADDR_OFS_LOC) begin
				state_d.ofs_loc = reg_wdata_in;
			end else if (reg_addr_in == `TMCR_ADDR_OFS_R2) begin
				state_d.ofs_r2 = reg_wdata_in;
			end else if (reg_addr_in == `TMCR_ADDR_CFG2) begin
				// (RQ8) fan flags not writable
				state_d.cfg2 = reg_wdata_in;
				state_d.cfg2[`TMCR_BIT_FAN3:`TMCR_BIT_FAN1] = 3'h0;
			end
		end

		// (RQ7) flags follow sensing when enabled
		if (state_d.cfg2[`TMCR_BIT_DETECT_EN]) begin
			state_d.cfg2[`TMCR_BIT_FAN3:`TMCR_BIT_FAN1] = state_q.sense_sync;
		end else begin
			state_d.cfg2[`TMCR_BIT_FAN3:`TMCR_BIT_FAN1] = 3'h0;
		end

		// Fan drive outputs
		// (RQ13) halt forces fan-off level
		if (state_q.cfg2[`TMCR_BIT_HALT]) begin
			state_d.fan_drive = {FAN_COUNT{drive_polarity_invert_in}};
		end else begin
			state_d.fan_drive = fan_drive_in;
		end

		// Conversion sequencer
		case (state_q.seq)
			TMCR_SEQ_IDLE: begin
				if (state_q.cfg2[`TMCR_BIT_HALT]) begin
					state_d.seq = TMCR_SEQ_HALT;
				end else if (state_q.cfg2[`TMCR_BIT_SINGLE]) begin
					// (RQ11) (RQ12) single input repeatedly
					state_d.chan = tmcr_chan_e'(channel_select_in);
					// (RQ14) reserved code waits
					if (chan_is_real(tmcr_chan_e'(channel_select_in))) begin
						state_d.start = 1'b1;
						state_d.seq = TMCR_SEQ_CONVERT;
					end
				end else begin
					// (RQ14) scan skips reserved codes
					if (!chan_is_real(state_q.chan)) begin
						state_d.chan = TMCR_CH_CORE;
					end
					state_d.start = 1'b1;
					state_d.seq = TMCR_SEQ_CONVERT;
				end
			end
			TMCR_SEQ_CONVERT: begin
				if (single_channel_convert_done_in) begin
					if (single_channel_convert_chan_in == TMCR_CH_CORE) begin
						state_d.res_core = single_channel_convert_raw_in;
					end else if (single_channel_convert_chan_in == TMCR_CH_SUPPLY) begin
						state_d.res_supply = single_channel_convert_raw_in;
					end
					if (!state_q.cfg2[`TMCR_BIT_SINGLE]) begin
						state_d.chan = chan_next(state_q.chan);
					end
					state_d.seq = TMCR_SEQ_IDLE;
				end
			end
			TMCR_SEQ_HALT: begin
				if (!state_q.cfg2[`TMCR_BIT_HALT]) begin
					state_d.seq = TMCR_SEQ_IDLE;
				end
			end
			default: begin
				state_d.seq = TMCR_SEQ_IDLE;
			end
		endcase

		// Read data register
		if (reg_addr_in == `TMCR_ADDR_TEST) begin
			state_d.rdata = {7'h00, state_q.test_en};
		end else if (reg_addr_in == `TMCR_ADDR_OFS_R1) begin
			state_d.rdata = state_q.ofs_r1;
		end else if (reg_addr_in == `TMCR_ADDR_OFS_LOC) begin
			state_d.rdata = state_q.ofs_loc;
		end else if (reg_addr_in == `TMCR_ADDR_OFS_R2) begin
			state_d.rdata = state_q.ofs_r2;
		end else if (reg_addr_in == `TMCR_ADDR_CFG2) begin
			state_d.rdata = state_q.cfg2;
		end else begin
			state_d.rdata = 8'h00;
		end
	end

	// State register
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= '0;
			state_q.test_en <= 1'b0;
			state_q.ofs_r1 <= `TMCR_RST_OFS;
			state_q.ofs_loc <= `TMCR_RST_OFS;
			state_q.ofs_r2 <= `TMCR_RST_OFS;
			state_q.cfg2 <= `TMCR_RST_CFG2;
			state_q.seq <= TMCR_SEQ_IDLE;
			state_q.chan <= TMCR_CH_CORE;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************
	// Offset correction
	// ********************
	// (RQ4) remote one offset
	tmcr_temp_adjust #(.RESULT_W(RESULT_W)) u_adj_r1 (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.valid_in(state_q.seq == TMCR_SEQ_CONVERT && single_channel_convert_done_in && single_channel_convert_chan_in == TMCR_CH_REMOTE1),
		.raw_in(single_channel_convert_raw_in),
		.offset_in(state_q.ofs_r1),
		.adjusted_out(adj_r1),
		.valid_out(adj_r1_valid)
	);

	// (RQ5) local offset
	tmcr_temp_adjust #(.RESULT_W(RESULT_W)) u_adj_loc (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.valid_in(state_q.seq == TMCR_SEQ_CONVERT && single_channel_convert_done_in && single_channel_convert_chan_in == TMCR_CH_LOCAL),
		.raw_in(single_channel_convert_raw_in),
		.offset_in(state_q.ofs_loc),
		.adjusted_out(adj_loc),
		.valid_out(adj_loc_valid)
	);

	// (RQ6) remote two offset
	tmcr_temp_adjust #(.RESULT_W(RESULT_W)) u_adj_r2 (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.valid_in(state_q.seq == TMCR_SEQ_CONVERT && single_channel_convert_done_in && single_channel_convert_chan_in == TMCR_CH_REMOTE2),
		.raw_in(single_channel_convert_raw_in),
		.offset_in(state_q.ofs_r2),
		.adjusted_out(adj_r2),
		.valid_out(adj_r2_valid)
	);

	// Corrected temperature results held until next conversion
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			res_r1_q <= '0;
			res_loc_q <= '0;
			res_r2_q <= '0;
		end else begin
			if (adj_r1_valid) begin
				res_r1_q <= adj_r1;
			end
			if (adj_loc_valid) begin
				res_loc_q <= adj_loc;
			end
			if (adj_r2_valid) begin
				res_r2_q <= adj_r2;
			end
		end
	end

	// ********************
	// Outputs
	// ********************
	assign reg_rdata_out = state_q.rdata;
	assign fan_drive_out = state_q.fan_drive;
	assign remote_one_temp_out = res_r1_q;
	assign local_temp_out = res_loc_q;
	assign remote_two_temp_out = res_r2_q;
	assign core_voltage_out = state_q.res_core;
	assign supply_voltage_out = state_q.res_supply;
	assign single_channel_convert_start_out = state_q.start;
	assign single_channel_convert_chan_out = state_q.chan;
	assign board_test_mode_enable_out = state_q.test_en;
	// (RQ9) averaging off
	assign averaging_disable_out = state_q.cfg2[`TMCR_BIT_AVG_OFF];
	// (RQ10) divider bypass
	assign core_input_divider_bypass_out = state_q.cfg2[`TMCR_BIT_BYPASS];
	assign single_channel_convert_out = state_q.cfg2[`TMCR_BIT_SINGLE];
	assign fan_halt_request_out = state_q.cfg2[`TMCR_BIT_HALT];
endmodule : tmcr_config_regs
`default_nettype wire

// ### verification/tmcr_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Port-level checks
// ****************************
module tmcr_config_regs_props #(
	parameter int FAN_COUNT = 3
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic config_lock_in,
	input wire logic [2:0] channel_select_in,
	input wire logic drive_polarity_invert_in,
	input wire logic [FAN_COUNT-1:0] fan_drive_in,
	input wire logic [FAN_COUNT-1:0] fan_drive_out,
	input wire logic single_channel_convert_start_out,
	input wire tmcr_pkg::tmcr_chan_e single_channel_convert_chan_out,
	input wire logic board_test_mode_enable_out,
	input wire logic single_channel_convert_out,
	input wire logic fan_halt_request_out
);
	import tmcr_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	halt_fan_off_a: assert property (
		fan_halt_request_out [*2] ##0 $stable(drive_polarity_invert_in)
		|-> fan_drive_out == {FAN_COUNT{drive_polarity_invert_in}}) else $error("fan not off");
	run_fan_copy_a: assert property (
		(!fan_halt_request_out) [*2] |-> fan_drive_out == $past(fan_drive_in)) else $error("fan copy");
	lock_freeze_a: assert property (
		config_lock_in [*3] ##0 reg_write_in |=> $stable({board_test_mode_enable_out,
		single_channel_convert_out, fan_halt_request_out})) else $error("locked write took");
	start_pulse_a: assert property (single_channel_convert_start_out |=> !single_channel_convert_start_out)
		else $error("start too long");
	start_code_a: assert property (single_channel_convert_start_out |-> single_channel_convert_chan_out inside {TMCR_CH_CORE,
		TMCR_CH_SUPPLY, TMCR_CH_REMOTE1, TMCR_CH_LOCAL, TMCR_CH_REMOTE2}) else $error("bad chan");
	single_sel_a: assert property (single_channel_convert_start_out && single_channel_convert_out
		&& $stable(channel_select_in) |-> single_channel_convert_chan_out == channel_select_in) else $error("sel");
	offset_back_a: assert property ((reg_write_in && !config_lock_in
		&& reg_addr_in inside {8'h70, 8'h71, 8'h72}) ##1 ($stable(reg_addr_in) && !reg_write_in)
		|=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("offset readback");
	test_res_a: assert property ($past(reg_addr_in) == 8'h6F |-> reg_rdata_out[7:1] == 7'h00)
		else $error("test bits");
	flags_off_a: assert property ($past(reg_addr_in) == 8'h73 && !reg_rdata_out[0]
		|-> reg_rdata_out[3:1] == 3'h0) else $error("flags");
	cover property (single_channel_convert_start_out && single_channel_convert_out);
	cover property (fan_halt_request_out && drive_polarity_invert_in);
	cover property (config_lock_in && reg_write_in);
endmodule : tmcr_config_regs_props
`default_nettype wire

// ### verification/tmcr_converter_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Converter answering starts
// ****************************
module tmcr_converter_model (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire tmcr_pkg::tmcr_chan_e chan_in,
	output logic done_out,
	output tmcr_pkg::tmcr_chan_e chan_out,
	output logic [9:0] raw_out
);
	import tmcr_pkg::*;
	int cnt;
	int wait_q;
	// Varying delay of 3 to 7 cycles, result pulse then bus inverted
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt <= 0;
			wait_q <= 0;
			done_out <= 1'b0;
			chan_out <= TMCR_CH_CORE;
			raw_out <= 10'h000;
		end else begin
			done_out <= 1'b0;
			raw_out <= ~raw_out;
			if (start_in) begin
				wait_q <= 3 + cnt % 5;
				chan_out <= chan_in;
				cnt <= cnt + 1;
			end else if (wait_q > 0) begin
				wait_q <= wait_q - 1;
				if (wait_q == 1) begin
					done_out <= 1'b1;
					raw_out <= 10'((cnt * 149) % 1024);
				end
			end
		end
	end
endmodule : tmcr_converter_model
`default_nettype wire

// ### verification/tmcr_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Bench with register model
// ****************************
module tmcr_config_regs_bench;
	import tmcr_pkg::*;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic reg_write_in = 1'b0;
	logic config_lock_in = 1'b0;
	logic drive_polarity_invert_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [2:0] channel_select_in = 3'h0;
	logic [2:0] four_wire_sense_in = 3'h0;
	logic [2:0] fan_drive_in = 3'h0;
	logic [31:0] r = 32'h8F0A661B;
	logic [7:0] m [5] = '{default: 8'h00};
	logic [7:0] reg_rdata_out;
	logic [2:0] fan_drive_out;
	logic [9:0] single_channel_convert_raw_in, remote_one_temp_out, local_temp_out, remote_two_temp_out;
	logic [9:0] core_voltage_out, supply_voltage_out;
	logic single_channel_convert_done_in, single_channel_convert_start_out, board_test_mode_enable_out, averaging_disable_out;
	logic core_input_divider_bypass_out, single_channel_convert_out, fan_halt_request_out;
	tmcr_chan_e single_channel_convert_chan_in, single_channel_convert_chan_out;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int starts = 0;
	tmcr_config_regs tmcr_config_regs_i (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in),
		.reg_rdata_out(reg_rdata_out),
		.config_lock_in(config_lock_in),
		.channel_select_in(channel_select_in),
		.four_wire_sense_in(four_wire_sense_in),
		.drive_polarity_invert_in(drive_polarity_invert_in),
		.fan_drive_in(fan_drive_in),
		.fan_drive_out(fan_drive_out),
		.single_channel_convert_done_in(single_channel_convert_done_in),
		.single_channel_convert_chan_in(single_channel_convert_chan_in),
		.single_channel_convert_raw_in(single_channel_convert_raw_in),
		.remote_one_temp_out(remote_one_temp_out),
		.local_temp_out(local_temp_out),
		.remote_two_temp_out(remote_two_temp_out),
		.core_voltage_out(core_voltage_out),
		.supply_voltage_out(supply_voltage_out),
		.single_channel_convert_start_out(single_channel_convert_start_out),
		.single_channel_convert_chan_out(single_channel_convert_chan_out),
		.board_test_mode_enable_out(board_test_mode_enable_out),
		.averaging_disable_out(averaging_disable_out),
		.core_input_divider_bypass_out(core_input_divider_bypass_out),
		.single_channel_convert_out(single_channel_convert_out),
		.fan_halt_request_out(fan_halt_request_out)
	);
	tmcr_converter_model tmcr_converter_model_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.start_in(single_channel_convert_start_out), .chan_in(single_channel_convert_chan_out), .done_out(single_channel_convert_done_in),
		.chan_out(single_channel_convert_chan_in), .raw_out(single_channel_convert_raw_in));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// Expected read value from the model
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h6F: return {7'h00, m[0][0]};
			8'h70, 8'h71, 8'h72: return m[a - 8'h6F];
			8'h73: return {m[4][7:4], m[4][0] ? four_wire_sense_in : 3'h0, m[4][0]};
			default: return 8'h00;
		endcase
	endfunction : exp_rd
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
		if (!config_lock_in && a inside {[8'h6F:8'h73]}) m[a - 8'h6F] = d;
		@(posedge mclk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		reg_addr_in <= a;
		repeat (3) @(posedge mclk_in);
		chk("rdata", {2'h0, exp_rd(a)}, {2'h0, reg_rdata_out});
		chk("levels", {5'h00, m[4][7:4], m[0][0]}, {5'h00, fan_halt_request_out,
			single_channel_convert_out, core_input_divider_bypass_out, averaging_disable_out,
			board_test_mode_enable_out});
	endtask : rd
	// Result expected from raw value and stored offset
	task automatic chk_res(input tmcr_chan_e c, input logic [9:0] raw);
		int v;
		logic [7:0] o;
		o = (c == TMCR_CH_REMOTE1) ? m[1] : (c == TMCR_CH_LOCAL) ? m[2] : m[3];
		v = int'(raw) + 2 * int'($signed(o));
		v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
		repeat (3) @(posedge mclk_in);
		case (c)
			TMCR_CH_CORE: chk("core", raw, core_voltage_out);
			TMCR_CH_SUPPLY: chk("supply", raw, supply_voltage_out);
			TMCR_CH_REMOTE1: chk("rem1", v[9:0], remote_one_temp_out);
			TMCR_CH_LOCAL: chk("local", v[9:0], local_temp_out);
			default: chk("rem2", v[9:0], remote_two_temp_out);
		endcase
	endtask : chk_res
	task automatic results;
		if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	initial begin
		forever #2 mclk_in = ~mclk_in;
	end
	// Random source and fan drive stimulus
	always @(posedge mclk_in) begin
		r <= lfsr(r);
		fan_drive_in <= r[2:0];
	end
	// Start watch and hang limit
	always @(posedge mclk_in) begin
		cyc++;
		if (single_channel_convert_start_out) starts++;
		if (single_channel_convert_start_out && single_channel_convert_out) chk("chan", {7'h00, channel_select_in}, {7'h00, single_channel_convert_chan_out});
		if (cyc == 5000) begin
			miscompares++;
			results();
		end
	end
	always @(posedge mclk_in) begin
		if (single_channel_convert_done_in && !fan_halt_request_out) chk_res(single_channel_convert_chan_in, single_channel_convert_raw_in);
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		four_wire_sense_in <= r[2:0];
		for (int a = 8'h6F; a <= 8'h74; a++) rd(8'(a));
		wr(8'h73, 8'h81);
		repeat (12) @(posedge mclk_in);
		rd(8'h73);
		for (int i = 0; i < 6; i++) begin
			wr(8'h6F + 8'(i), (i == 0) ? {7'h00, r[3]} : (i == 4) ? (r[7:0] | 8'h80) : r[7:0]);
			rd(8'h6F + 8'(i));
		end
		wr(8'h70, 8'h7F);
		wr(8'h71, 8'h80);
		wr(8'h72, 8'hFE);
		wr(8'h73, 8'h10);
		repeat (300) @(posedge mclk_in);
		for (int c = 0; c < 8; c++) begin
			wr(8'h73, 8'h80);
			repeat (12) @(posedge mclk_in);
			channel_select_in <= 3'(c);
			wr(8'h73, 8'h40);
			starts = 0;
			repeat (60) @(posedge mclk_in);
			chk("idle", {9'h000, c inside {0, 3, 4}}, {9'h000, starts == 0});
		end
		for (int v = 0; v < 2; v++) begin
			drive_polarity_invert_in <= v[0];
			wr(8'h73, 8'h80);
			repeat (4) @(posedge mclk_in);
			chk("fan", {7'h00, {3{v[0]}}}, {7'h00, fan_drive_out});
		end
		wr(8'h73, 8'h00);
		config_lock_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		for (int i = 0; i < 5; i++) begin
			wr(8'h6F + 8'(i), (i == 0) ? 8'h01 : 8'hFF);
			rd(8'h6F + 8'(i));
		end
		results();
	end
endmodule : tmcr_config_regs_bench
bind tmcr_config_regs tmcr_config_regs_props #(.FAN_COUNT(FAN_COUNT)) tmcr_config_regs_props_i (
	.mclk_in(mclk_in),
	.reset_n_in(reset_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_write_in(reg_write_in),
	.reg_rdata_out(reg_rdata_out),
	.config_lock_in(config_lock_in),
	.channel_select_in(channel_select_in),
	.drive_polarity_invert_in(drive_polarity_invert_in),
	.fan_drive_in(fan_drive_in),
	.fan_drive_out(fan_drive_out),
	.single_channel_convert_start_out(single_channel_convert_start_out),
	.single_channel_convert_chan_out(single_channel_convert_chan_out),
	.board_test_mode_enable_out(board_test_mode_enable_out),
	.single_channel_convert_out(single_channel_convert_out),
	.fan_halt_request_out(fan_halt_request_out)
);
`default_nettype wire
